// file: logic/fc_busy_timer.sv
// busy timer: counts the duration of one flash operation
// assumes start is a one-cycle pulse and len is at least one
`timescale 1ns/1ps
`include "fc_defines.svh"
module fc_busy_timer
    import fc_pkg::*;
(
    // clock and reset
    input  wire logic  clk,
    input  wire logic  sys_rst,
    // link to the controller
    fc_timer_if.tmr    t
);

    fc_tmr_s s_ff;
    fc_tmr_s nxt_s;

    // ************************************************************
    // countdown
    // ************************************************************
    // load on start, pulse done as the count runs out
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;
        if (t.start) begin
            nxt_s.cnt = t.len;
        end else if (s_ff.cnt != '0) begin
            nxt_s.cnt  = s_ff.cnt - 1'b1;
            nxt_s.done = (s_ff.cnt == `FC_TMR_W'(1));
        end
    end

    // state register
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign t.done = s_ff.done;

endmodule

// file: logic/fc_defines.svh
// constants of the flash protection and download controller
// assumes a 100 MHz core clock and a 16 kB array of 512-byte pages
`ifndef FC_DEFINES_SVH
`define FC_DEFINES_SVH

// ************************************************************
// special function register addresses
// ************************************************************
`define FC_SFR_CMD     8'hB9
`define FC_SFR_KEY     8'hB7
`define FC_SFR_RDPROT  8'hBA
`define FC_SFR_LOCK    8'hBB
`define FC_SFR_DATA    8'hBC
`define FC_SFR_WP0     8'hBD
`define FC_SFR_WP1     8'hBE
`define FC_SFR_ALO     8'hC6
`define FC_SFR_AHI     8'hC7

// ************************************************************
// commands, keys and emulator codes
// ************************************************************
`define FC_CMD_WRITE   8'h01
`define FC_CMD_ERPG    8'h02
`define FC_CMD_ERALL   8'h03
`define FC_CMD_READ    8'h04
`define FC_CMD_PGWR    8'h05
`define FC_CMD_VERIFY  8'h06
`define FC_CMD_PROT    8'h08
`define FC_ACCESS_KEY  8'h3B
`define FC_EMU_LOAD    8'h49
`define FC_EMU_COPY    8'h46
`define FC_ERASED      8'hFF

// ************************************************************
// status codes and protection area
// ************************************************************
`define FC_ST_OK       8'h00
`define FC_ST_REFUSED  8'h01
`define FC_ST_KEYERR   8'h02
`define FC_ST_MISMATCH 8'h04
`define FC_PROT_BASE   14'h3FFA
`define FC_PROT_LAST   3'd5
`define FC_LAST_PAGE   5'd31

// ************************************************************
// timing
// ************************************************************
`define FC_CLK_NS      10
`define FC_T_WRITE_NS  30000
`define FC_T_PAGE_NS   20000000
`define FC_T_ALL_NS    200000000
`define FC_T_PGWR_NS   21000000
`define FC_T_READ_NS   100
`define FC_CYC(ns)     (((ns) + `FC_CLK_NS - 1) / `FC_CLK_NS)
`define FC_TMR_W       25

`endif

// file: logic/fc_flash_ctrl.sv
// flash command sequencer with page protection and download-mode
// emulator register writes
// assumes an asynchronous-read array on arr_addr and a core that
// stops fetching while core_stall is high
`timescale 1ns/1ps
`include "fc_defines.svh"

// Overview of operation
// R01: emulator load code puts data in scratch
// R02: emulator copy code writes scratch to register
// R03: emulator codes honoured only in download mode
// R04: host loads scratch first, then copies it
// R05: erased protection bytes mean nothing protected
// R06: protection enforced only if last page protected
// R07: new protection active only after a reset
// R08: after reset only mass erase clears protection
// R09: protection bits only ever go one to zero
// R10: protection bytes stay readable, rest of page hidden
// R11: write 30 us, page 20 ms, all 200 ms
// R12: read or verify 100 ns, page-and-write 21 ms
// R13: core held until flash operation finishes
// R14: no interrupt service while held; timers run
// R15: command register write starts the operation
// R16: low download pin at reset enters download mode
// R17: download kernel may write anywhere in array; the code still refuses writes to write-protected pages
// R18: download mode refuses reads of read-protected pages
// R19: download mode refuses writes to write-protected pages
// R20: one write-protect bit for each of 32 pages
// R21: zero bit protects, erased one leaves open
// R22: command 08h programs the staged protection bytes
// R23: access key 3Bh before each command, fixed
// R24: refused command changes nothing, still releases core
module fc_flash_ctrl
    import fc_pkg::*;
#(
    parameter int unsigned P_PAGE_CYC = `FC_CYC(`FC_T_PAGE_NS),
    parameter int unsigned P_ALL_CYC  = `FC_CYC(`FC_T_ALL_NS),
    parameter int unsigned P_PGWR_CYC = `FC_CYC(`FC_T_PGWR_NS)
)(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // board pin
    input  wire logic         download_enable_pin_n,
    // core register port
    input  wire logic         sfr_wr,
    input  wire logic [7:0]   sfr_waddr,
    input  wire logic [7:0]   sfr_wdata,
    input  wire logic [7:0]   sfr_raddr,
    output logic      [7:0]   sfr_rdata,
    // download kernel emulator commands
    input  wire logic         emu_valid,
    input  wire logic [7:0]   emu_code,
    input  wire logic [7:0]   emu_data,
    // core side status
    output logic      [7:0]   scratch_working_reg,
    output logic              core_stall,
    output logic              download_mode,
    // flash array
    output logic              arr_rd,
    output logic              arr_wr,
    output logic              arr_erase_page,
    output logic              arr_erase_all,
    output logic      [13:0]  arr_addr,
    output logic      [7:0]   arr_wdata,
    input  wire logic [7:0]   arr_rdata
);

    localparam logic [`FC_TMR_W-1:0] WR_CYC = `FC_TMR_W'(`FC_CYC(`FC_T_WRITE_NS));
    localparam logic [`FC_TMR_W-1:0] RD_CYC = `FC_TMR_W'(`FC_CYC(`FC_T_READ_NS));

    fc_ctl_s     s;
    fc_ctl_s     nxt_s;
    fc_timer_if  tif ();
    logic        emu_copy;
    logic        we;
    logic [7:0]  wa;
    logic [7:0]  wd;
    logic [13:0] ca;
    logic        bad;

    // ************************************************************
    // protection decode
    // ************************************************************
    // scheme is live only when the last page is write protected
    function automatic logic scheme_on(input logic [5:0][7:0] a);
        return !a[5][7];
    endfunction

    // write/erase lock of one page, one bit per page
    function automatic logic wp_page(input logic [5:0][7:0] a, input logic [4:0] pg);
        logic [31:0] w;
        w = {a[5], a[4], a[3], a[2]};
        return scheme_on(a) && !w[pg];
    endfunction

    // read lock; protection bytes themselves stay readable
    function automatic logic rd_blk(input logic [5:0][7:0] a, input logic [13:0] adr);
        return scheme_on(a) && !a[1][adr[13:11]] && (adr < `FC_PROT_BASE);
    endfunction

    // position of a protection byte within the stored copy
    function automatic logic [2:0] pidx(input logic [13:0] adr);
        return adr[2:0] - 3'd2;
    endfunction

    // busy time of each array command
    function automatic logic [`FC_TMR_W-1:0] cmd_len(input logic [7:0] c);
        unique case (c)
            `FC_CMD_WRITE: return WR_CYC;
            `FC_CMD_ERPG:  return `FC_TMR_W'(P_PAGE_CYC);
            `FC_CMD_ERALL: return `FC_TMR_W'(P_ALL_CYC);
            `FC_CMD_PGWR:  return `FC_TMR_W'(P_PGWR_CYC);
            default:       return RD_CYC;
        endcase
    endfunction

    // ************************************************************
    // write source selection
    // ************************************************************
    // emulator copy stands in for a core write in download mode
    assign emu_copy = s.dl && emu_valid && (emu_code == `FC_EMU_COPY); // see R02 R03
    assign we       = emu_copy || sfr_wr;
    assign wa       = emu_copy ? emu_data : sfr_waddr;
    assign wd       = emu_copy ? s.scratch : sfr_wdata;
    assign ca       = {s.ahi[5:0], s.alo};

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb begin
        nxt_s        = s;
        bad          = 1'b0;
        nxt_s.sync1  = download_enable_pin_n;
        nxt_s.sync2  = s.sync1;
        nxt_s.rd     = 1'b0;
        nxt_s.wr     = 1'b0;
        nxt_s.epg    = 1'b0;
        nxt_s.eall   = 1'b0;
        nxt_s.tstart = 1'b0;
        // emulator load of the scratch register
        if (s.dl && emu_valid && emu_code == `FC_EMU_LOAD) begin
            nxt_s.scratch = emu_data; // see R01 R03
        end
        unique case (s.st)
            // fetch the stored protection bytes after reset
            S_BOOT: begin
                nxt_s.addr = `FC_PROT_BASE + 14'(s.idx);
                nxt_s.rd   = 1'b1;
                nxt_s.st   = S_LOAD;
            end
            S_LOAD: begin
                nxt_s.stored[s.idx] = arr_rdata;
                if (s.idx == `FC_PROT_LAST) begin
                    nxt_s.act = nxt_s.stored; // see R07 R08
                    nxt_s.dl  = !s.sync2;     // see R16 R17
                    nxt_s.idx = 3'd0;
                    nxt_s.st  = S_IDLE;
                end else begin
                    nxt_s.idx = s.idx + 3'd1;
                    nxt_s.st  = S_BOOT;
                end
            end
            // register writes and command start
            S_IDLE: begin
                if (we) begin
                    unique case (wa)
                        `FC_SFR_KEY:    nxt_s.key  = wd;
                        `FC_SFR_LOCK:   nxt_s.lock = wd;
                        `FC_SFR_RDPROT: nxt_s.rp   = wd;
                        `FC_SFR_DATA:   nxt_s.data = wd;
                        `FC_SFR_WP0:    nxt_s.b0   = wd;
                        `FC_SFR_WP1:    nxt_s.b1   = wd;
                        `FC_SFR_ALO:    nxt_s.alo  = wd;
                        `FC_SFR_AHI:    nxt_s.ahi  = wd;
                        `FC_SFR_CMD: begin
                            nxt_s.key = 8'h00;
                            nxt_s.cmd = wd;
                            if (s.key != `FC_ACCESS_KEY) begin
                                nxt_s.stat = `FC_ST_KEYERR; // see R23
                            end else if (wd == `FC_CMD_PROT) begin
                                if (s.stored[0] != `FC_ERASED && s.lock != s.stored[0]) begin
                                    nxt_s.stat = `FC_ST_REFUSED;
                                end else begin
                                    // merge: bits can only be cleared
                                    nxt_s.stored[0] = (s.stored[0] == `FC_ERASED) ? s.lock : s.stored[0];
                                    nxt_s.stored[1] = s.stored[1] & s.rp;  // see R09 R21
                                    nxt_s.stored[2] = s.stored[2] & s.b0;  // see R20
                                    nxt_s.stored[3] = s.stored[3] & s.b1;
                                    nxt_s.stored[4] = s.stored[4] & s.alo;
                                    nxt_s.stored[5] = s.stored[5] & s.ahi;
                                    nxt_s.stat   = `FC_ST_OK;
                                    nxt_s.idx    = 3'd0;
                                    nxt_s.addr   = `FC_PROT_BASE;
                                    nxt_s.wdata  = nxt_s.stored[0];
                                    nxt_s.wr     = 1'b1;
                                    nxt_s.tstart = 1'b1;
                                    nxt_s.tlen   = WR_CYC;
                                    nxt_s.st     = S_PROG; // see R22
                                end
                            end else if (wd >= `FC_CMD_WRITE && wd <= `FC_CMD_VERIFY) begin
                                if (wd == `FC_CMD_READ || wd == `FC_CMD_VERIFY) begin
                                    bad = rd_blk(s.act, ca); // see R10 R18
                                end else if (wd != `FC_CMD_ERALL) begin
                                    bad = wp_page(s.act, ca[13:9]); // see R06 R19
                                end
                                nxt_s.st     = S_RUN; // see R15
                                nxt_s.addr   = ca;
                                nxt_s.wdata  = s.data;
                                nxt_s.tstart = 1'b1;
                                nxt_s.tlen   = bad ? `FC_TMR_W'(1) : cmd_len(wd); // see R11 R12 R24
                                nxt_s.stat   = bad ? `FC_ST_REFUSED : `FC_ST_OK;
                                if (!bad) begin
                                    nxt_s.wr   = (wd == `FC_CMD_WRITE) || (wd == `FC_CMD_PGWR);
                                    nxt_s.epg  = (wd == `FC_CMD_ERPG) || (wd == `FC_CMD_PGWR);
                                    nxt_s.eall = (wd == `FC_CMD_ERALL);
                                    nxt_s.rd   = (wd == `FC_CMD_READ) || (wd == `FC_CMD_VERIFY);
                                    // keep the stored copy in step with the array
                                    if (nxt_s.eall || (nxt_s.epg && ca[13:9] == `FC_LAST_PAGE)) begin
                                        nxt_s.stored = '1; // see R08
                                    end
                                    if (nxt_s.wr && ca >= `FC_PROT_BASE) begin
                                        nxt_s.stored[pidx(ca)] = nxt_s.stored[pidx(ca)] & s.data;
                                    end
                                end
                            end else begin
                                nxt_s.stat = `FC_ST_REFUSED;
                            end
                        end
                        default: ;
                    endcase
                end
            end
            // array operation under way
            S_RUN: begin
                if (tif.done) begin
                    nxt_s.st = S_IDLE; // see R13 R24
                    if (s.stat == `FC_ST_OK && s.cmd == `FC_CMD_READ) begin
                        nxt_s.data = arr_rdata;
                    end
                    if (s.stat == `FC_ST_OK && s.cmd == `FC_CMD_VERIFY && arr_rdata != s.data) begin
                        nxt_s.stat = `FC_ST_MISMATCH;
                    end
                end
            end
            // programming the six protection bytes in turn
            S_PROG: begin
                if (tif.done) begin
                    if (s.idx == `FC_PROT_LAST) begin
                        nxt_s.st = S_IDLE;
                    end else begin
                        nxt_s.idx    = s.idx + 3'd1;
                        nxt_s.addr   = s.addr + 14'd1;
                        nxt_s.wdata  = s.stored[nxt_s.idx];
                        nxt_s.wr     = 1'b1;
                        nxt_s.tstart = 1'b1;
                        nxt_s.tlen   = WR_CYC;
                    end
                end
            end
            default: nxt_s.st = S_IDLE;
        endcase
        // core and its interrupts wait while the array is busy
        nxt_s.stall = (nxt_s.st != S_IDLE); // see R13 R14
        // register read mux
        unique case (sfr_raddr)
            `FC_SFR_CMD:    nxt_s.rdata = s.stat;
            `FC_SFR_DATA:   nxt_s.rdata = s.data;
            `FC_SFR_AHI:    nxt_s.rdata = s.ahi;
            `FC_SFR_ALO:    nxt_s.rdata = s.alo;
            `FC_SFR_RDPROT: nxt_s.rdata = s.rp;
            `FC_SFR_WP0:    nxt_s.rdata = s.b0;
            `FC_SFR_WP1:    nxt_s.rdata = s.b1;
            default:        nxt_s.rdata = 8'h00;
        endcase
    end

    // state register; erased protection out of reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s        <= '0;
            s.st     <= S_BOOT;
            s.stored <= '1; // see R05
            s.act    <= '1;
            s.stall  <= 1'b1;
            s.lock   <= `FC_ERASED; // an unwritten lock key stays erased
            s.sync1  <= 1'b1;
            s.sync2  <= 1'b1;
        end else begin
            s <= nxt_s;
        end
    end

    // ************************************************************
    // timer and outputs
    // ************************************************************
    assign tif.start = s.tstart;
    assign tif.len   = s.tlen;

    fc_busy_timer u_tmr (
        .clk     (clk),
        .sys_rst (sys_rst),
        .t       (tif.tmr)
    );

    assign sfr_rdata           = s.rdata;
    assign scratch_working_reg = s.scratch;
    assign core_stall          = s.stall;
    assign download_mode       = s.dl;
    assign arr_rd              = s.rd;
    assign arr_wr              = s.wr;
    assign arr_erase_page      = s.epg;
    assign arr_erase_all       = s.eall;
    assign arr_addr            = s.addr;
    assign arr_wdata           = s.wdata;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_emu_load;
        s.dl && emu_valid && emu_code == `FC_EMU_LOAD |=> s.scratch == $past(emu_data);
    endproperty
    a_emu_load: assert property (p_emu_load) else $error("scratch not loaded"); // see R01

    property p_emu_copy;
        s.st == S_IDLE && emu_copy && emu_data == `FC_SFR_AHI |=> s.ahi == $past(s.scratch);
    endproperty
    a_emu_copy: assert property (p_emu_copy) else $error("scratch not copied"); // see R02

    property p_emu_off;
        !s.dl && emu_valid |=> $stable(s.scratch);
    endproperty
    a_emu_off: assert property (p_emu_off) else $error("emulator code outside download"); // see R03

    property p_act_hold;
        !(s.st == S_LOAD && s.idx == `FC_PROT_LAST) |=> $stable(s.act);
    endproperty
    a_act_hold: assert property (p_act_hold) else $error("protection changed without reset"); // see R07

    property p_one_way;
        (s.stored & ~$past(s.stored)) != '0 |-> s.epg || s.eall || $past(s.st) == S_LOAD;
    endproperty
    a_one_way: assert property (p_one_way) else $error("protection bit set back"); // see R09

    property p_rd_lock;
        s.rd && s.st == S_RUN |-> !rd_blk(s.act, s.addr);
    endproperty
    a_rd_lock: assert property (p_rd_lock) else $error("protected read issued"); // see R10

    property p_wp_lock;
        (s.wr || s.epg) && s.st == S_RUN |-> !wp_page(s.act, s.addr[13:9]);
    endproperty
    a_wp_lock: assert property (p_wp_lock) else $error("protected write issued"); // see R19

    property p_stall;
        s.wr && s.st == S_RUN |-> s.stall [*8] ##1 s.stall;
    endproperty
    a_stall: assert property (p_stall) else $error("core released early"); // see R13

    property p_no_start;
        s.st == S_IDLE && we && wa != `FC_SFR_CMD |=> !s.stall;
    endproperty
    a_no_start: assert property (p_no_start) else $error("stall without command"); // see R15

endmodule

// file: logic/fc_pkg.sv
// types shared by the flash controller and its busy timer
// assumes fc_defines.svh is on the include path
package fc_pkg;
`include "fc_defines.svh"

    // controller states, one-hot
    typedef enum logic [4:0] {
        S_BOOT = 5'b00001,
        S_LOAD = 5'b00010,
        S_IDLE = 5'b00100,
        S_RUN  = 5'b01000,
        S_PROG = 5'b10000
    } fc_state_e;

    // whole state of the controller
    typedef struct packed {
        fc_state_e             st;
        logic [2:0]            idx;
        logic                  sync1;
        logic                  sync2;
        logic                  dl;
        logic [7:0]            scratch;
        logic [7:0]            stat;
        logic [7:0]            key;
        logic [7:0]            lock;
        logic [7:0]            rp;
        logic [7:0]            b0;
        logic [7:0]            b1;
        logic [7:0]            ahi;
        logic [7:0]            alo;
        logic [7:0]            data;
        logic [7:0]            cmd;
        logic [7:0]            rdata;
        logic [7:0]            wdata;
        logic [5:0][7:0]       stored;
        logic [5:0][7:0]       act;
        logic [13:0]           addr;
        logic                  stall;
        logic                  rd;
        logic                  wr;
        logic                  epg;
        logic                  eall;
        logic                  tstart;
        logic [`FC_TMR_W-1:0]  tlen;
    } fc_ctl_s;

    // state of the busy timer
    typedef struct packed {
        logic [`FC_TMR_W-1:0]  cnt;
        logic                  done;
    } fc_tmr_s;

endpackage

// file: logic/fc_timer_if.sv
// start and done signals between the controller and its busy timer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`include "fc_defines.svh"
interface fc_timer_if;
    logic                  start;
    logic [`FC_TMR_W-1:0]  len;
    logic                  done;

    modport ctl (output start, output len, input done);
    modport tmr (input start, input len, output done);
endinterface

// file: testbench/fc_array_model.sv
// flash array model on the far side of the controller
// assumes one-cycle strobes on clk and an erased array at start
`timescale 1ns/1ps
module fc_array_model (
    // clock
    input  wire logic        clk,
    // array strobes and bus
    input  wire logic        wr,
    input  wire logic        ep,
    input  wire logic        ea,
    input  wire logic [13:0] addr,
    input  wire logic [7:0]  wdata,
    output logic      [7:0]  rdata
);
    logic [7:0] mem [0:16383];
    // erased cells read as ones
    initial foreach (mem[i]) mem[i] = 8'hFF;
    // asynchronous read of the addressed byte
    assign rdata = mem[addr];
    // programming only clears bits, erase sets them again
    always @(posedge clk) begin
        if (wr) mem[addr] <= mem[addr] & wdata;
        if (ep) for (int i = 0; i < 512; i++) mem[{addr[13:9], 9'h000} + i] <= 8'hFF;
        if (ea) foreach (mem[i]) mem[i] <= 8'hFF;
    end
endmodule

// file: testbench/flash_protect_and_download_ctrl_bench.sv
// self-checking bench of the flash controller
// assumes the array model and the shortened busy counts
`timescale 1ns/1ps
module flash_protect_and_download_ctrl_bench;
    import fc_pkg::*;
    logic clk = 0, sys_rst = 1, pin_n = 0, sfr_wr = 0, emu_valid = 0;
    logic [7:0] waddr = 0, wdata = 0, raddr = 0, ecode = 0, edata = 0, v;
    logic [13:0] aaddr;
    logic [7:0] scr, awd, ard;
    logic stall, dlm, awr, aep, aea, ars;
    int n_errors = 0, cmp_count = 0, n, n_rd = 0;

    // ************************************************************
    // clock, design and far side
    // ************************************************************
    always #5 clk = ~clk;
    fc_flash_ctrl #(.P_PAGE_CYC(40), .P_ALL_CYC(60), .P_PGWR_CYC(50)) dut (
        .clk(clk), .sys_rst(sys_rst), .download_enable_pin_n(pin_n),
        .sfr_wr(sfr_wr), .sfr_waddr(waddr), .sfr_wdata(wdata), .sfr_raddr(raddr),
        .sfr_rdata(v), .emu_valid(emu_valid), .emu_code(ecode), .emu_data(edata),
        .scratch_working_reg(scr), .core_stall(stall), .download_mode(dlm),
        .arr_rd(ars), .arr_wr(awr), .arr_erase_page(aep), .arr_erase_all(aea),
        .arr_addr(aaddr), .arr_wdata(awd), .arr_rdata(ard));
    fc_array_model mdl (.clk(clk), .wr(awr), .ep(aep), .ea(aea), .addr(aaddr),
        .wdata(awd), .rdata(ard));
    // counts array read strobes
    always @(posedge clk) if (ars) n_rd++;

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic wrap_up();
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one register write strobe
    task automatic sw(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_wr <= 1'b1;
        waddr <= a;
        wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask
    // one emulator command strobe
    task automatic emu(input logic [7:0] c, input logic [7:0] d);
        @(posedge clk);
        emu_valid <= 1'b1;
        ecode <= c;
        edata <= d;
        @(posedge clk);
        emu_valid <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        raddr <= a;
        repeat (3) @(posedge clk);
        #1 chk(v, exp);
    endtask
    // counts stalled cycles, bounded
    task automatic wait_idle();
        n = 0;
        @(posedge clk);
        #1;
        while (stall !== 1'b0 && n < 20000) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 20000) begin
            n_errors++;
            wrap_up();
        end
    endtask
    // a keyed command
    task automatic cmd(input logic [7:0] c);
        sw(8'hB7, 8'h3B);
        sw(8'hB9, c);
        wait_idle();
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_boot();
        wait_idle();
        chk(dlm, 1'b1);
        chk(8'(n_rd), 8'h06);
        $display("test boot done");
    endtask
    task automatic t_emu();
        emu(8'h49, 8'h5A);
        #1 chk(scr, 8'h5A);
        emu(8'h46, 8'hC7);
        rd(8'hC7, 8'h5A);
        $display("test emulator done");
    endtask
    task automatic t_write();
        sw(8'hC6, 8'h00);
        sw(8'hBC, 8'hA5);
        cmd(8'h01);
        chk(8'(n >= 2990), 8'h01);
        chk(mdl.mem[14'h1A00], 8'hA5);
        rd(8'hB9, 8'h00);
        $display("test write done");
    endtask
    task automatic t_read();
        sw(8'hBC, 8'h00);
        cmd(8'h04);
        chk(8'(n < 20), 8'h01);
        rd(8'hBC, 8'hA5);
        sw(8'hB9, 8'h01);
        rd(8'hB9, 8'h02);
        $display("test read and key done");
    endtask
    task automatic t_erase();
        cmd(8'h02);
        chk(8'(n >= 39), 8'h01);
        chk(mdl.mem[14'h1A00], 8'hFF);
        $display("test erase done");
    endtask
    // mid-run reset with the given pin level, then wait for boot
    task automatic t_reset(input logic pin);
        @(posedge clk);
        sys_rst <= 1'b1;
        pin_n <= pin;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        wait_idle();
    endtask
    // protection staged, programmed, live only after a reset
    task automatic t_prot();
        emu(8'h49, 8'h7F);
        emu(8'h46, 8'hC7);
        sw(8'hC6, 8'hFF);
        sw(8'hBE, 8'hDF);
        sw(8'hBD, 8'hFF);
        sw(8'hBA, 8'hFF);
        sw(8'hBB, 8'hFF);
        cmd(8'h08);
        chk(8'(n >= 18000), 8'h01);
        chk(mdl.mem[14'h3FFF], 8'h7F);
        chk(mdl.mem[14'h3FFD], 8'hDF);
        sw(8'hC7, 8'h1A);
        sw(8'hC6, 8'h00);
        sw(8'hBC, 8'h3C);
        cmd(8'h01);
        chk(mdl.mem[14'h1A00], 8'h3C);
        t_reset(1'b1);
        chk(dlm, 1'b0);
        emu(8'h49, 8'h11);
        #1 chk(scr, 8'h00);
        sw(8'hC7, 8'h1A);
        sw(8'hC6, 8'h00);
        sw(8'hBC, 8'h00);
        cmd(8'h01);
        chk(8'(n < 10), 8'h01);
        rd(8'hB9, 8'h01);
        chk(mdl.mem[14'h1A00], 8'h3C);
        cmd(8'h03);
        chk(mdl.mem[14'h3FFF], 8'hFF);
        $display("test protection done");
    endtask

    // reset with the download pin low, then the scenarios
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_boot();
        t_emu();
        t_write();
        t_read();
        t_erase();
        t_prot();
        wrap_up();
    end
endmodule
